// >>> ldw_pkg.sv
// Purpose: Shared constants, types and character tables for the display write port.
// Assumes: One 50 MHz clock; the write strobe, select line and data bus arrive from pins.
// Notes: The control byte layout equals the input-bus bit order during a control write.
package ldw_pkg;

  localparam int DATA_W = 8;
  localparam int DIGITS = 8;
  localparam int ADDR_W = 3;
  localparam int SEG_W = 7;

  // Input-bus bit positions during a control write.
  localparam int CTRL_SEQ_BIT = 7;
  localparam int CTRL_HEX_BIT = 6;
  localparam int CTRL_NODEC_BIT = 5;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_BANK_BIT = 3;
  localparam int CTRL_ADDR_MSB = 2;
  // Input-bus bit that carries the decimal point during a RAM write.
  localparam int POINT_BIT = 7;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RAM_RESET = 8'h00;
  localparam logic [2:0] SEQ_LAST = 3'h7;

  // Time each digit is lit during multiplexing.
  localparam int CLK_HZ = 50_000_000;
  localparam int DIGIT_TIME_US = 100;
  localparam int SCAN_CYCLES_DEFAULT = DIGIT_TIME_US * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic seq;
    logic hex;
    logic no_decode;
    logic run;
    logic bank_a;
    logic [ADDR_W-1:0] addr;
  } ldw_ctrl_type;

  // Segment bit 0 is segment a, bit 6 is segment g.
  typedef struct packed {
    logic point;
    logic [SEG_W-1:0] seg;
  } ldw_drive_type;

  function automatic logic [SEG_W-1:0] ldw_hex_seg(input logic [3:0] v);
    unique case (v)
      4'h0: ldw_hex_seg = 7'h3F;
      4'h1: ldw_hex_seg = 7'h06;
      4'h2: ldw_hex_seg = 7'h5B;
      4'h3: ldw_hex_seg = 7'h4F;
      4'h4: ldw_hex_seg = 7'h66;
      4'h5: ldw_hex_seg = 7'h6D;
      4'h6: ldw_hex_seg = 7'h7D;
      4'h7: ldw_hex_seg = 7'h07;
      4'h8: ldw_hex_seg = 7'h7F;
      4'h9: ldw_hex_seg = 7'h6F;
      4'hA: ldw_hex_seg = 7'h77;
      4'hB: ldw_hex_seg = 7'h7C;
      4'hC: ldw_hex_seg = 7'h39;
      4'hD: ldw_hex_seg = 7'h5E;
      4'hE: ldw_hex_seg = 7'h79;
      4'hF: ldw_hex_seg = 7'h71;
    endcase
  endfunction : ldw_hex_seg

  // Digits, then dash, E, H, L, P and blank.
  function automatic logic [SEG_W-1:0] ldw_codeb_seg(input logic [3:0] v);
    unique case (v)
      4'hA: ldw_codeb_seg = 7'h40;
      4'hB: ldw_codeb_seg = 7'h79;
      4'hC: ldw_codeb_seg = 7'h76;
      4'hD: ldw_codeb_seg = 7'h38;
      4'hE: ldw_codeb_seg = 7'h73;
      4'hF: ldw_codeb_seg = 7'h00;
      default: ldw_codeb_seg = ldw_hex_seg(v);
    endcase
  endfunction : ldw_codeb_seg

endpackage : ldw_pkg

// >>> ldw_write_port.sv
// Purpose: Processor write port and multiplexed drive of an eight-digit LED display.
// Assumes: Pins are asynchronous to clk; a common-cathode display is attached.
// Notes: Pin levels are resynchronised, so a write lands three clocks after the strobe rises.
// Notes on behaviour
// - Rising write strobe captures the eight input lines.
// - Select high loads control, low loads RAM.
// - Control bit six: high hex, low Code B.
// - Control bit five: high no-decode, low decode.
// - Control bit seven high announces sequential data.
// - Control bit four low stops scan, blanks display.
// - Control bit three picks RAM bank, decode only.
// - Bit seven low: bits two..zero address one digit.
// - RAM write: lines zero..seven are bits one..eight.
// - Separate segment, point and eight digit drives.
`timescale 1ns/1ps
module ldw_write_port
  import ldw_pkg::*;
#(
  parameter int unsigned DIGIT_CYCLES = SCAN_CYCLES_DEFAULT
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [DATA_W-1:0] in_line,
  input wire logic ctrl_select,
  input wire logic write_strobe,
  output ldw_drive_type segment_drive,
  output logic [DIGITS-1:0] digit_sink_n
);

  localparam int CNT_W = $clog2(DIGIT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIGIT_CYCLES - 1);

  logic [2:0] wr_sync_q;
  logic [1:0] sel_sync_q;
  logic [DATA_W-1:0] data_s1_q;
  logic [DATA_W-1:0] data_s2_q;
  ldw_ctrl_type ctrl_q;
  ldw_ctrl_type ctrl_d;
  logic seq_active_q;
  logic [ADDR_W-1:0] seq_cnt_q;
  logic [DATA_W-1:0] ram_q [2*DIGITS];
  logic [CNT_W-1:0] div_q;
  logic [ADDR_W-1:0] scan_q;
  ldw_drive_type drive_q;
  ldw_drive_type drive_d;
  logic [DIGITS-1:0] digit_n_q;

  // Input synchronisers; the strobe carries a third stage for its edge.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_sync_q <= 3'h0;
      sel_sync_q <= 2'h0;
      data_s1_q <= 8'h00;
      data_s2_q <= 8'h00;
    end
    else
    begin
      wr_sync_q <= {wr_sync_q[1:0], write_strobe};
      sel_sync_q <= {sel_sync_q[0], ctrl_select};
      data_s1_q <= in_line;
      data_s2_q <= data_s1_q;
    end
  end

  wire wr_edge = wr_sync_q[1] & ~wr_sync_q[2];
  wire ctrl_wr = wr_edge & sel_sync_q[1];
  wire ram_wr = wr_edge & ~sel_sync_q[1];
  wire seq_req = data_s2_q[CTRL_SEQ_BIT];
  wire [ADDR_W-1:0] wr_digit = seq_active_q ? seq_cnt_q : ctrl_q.addr;
  wire bank_sel = ctrl_q.no_decode | ctrl_q.bank_a;
  wire [ADDR_W:0] wr_index = {bank_sel, wr_digit};
  wire [ADDR_W:0] rd_index = {bank_sel, scan_q};
  wire [DATA_W-1:0] rd_byte = ram_q[rd_index];
  wire scan_en = ctrl_q.run && (div_q == CNT_LAST);

  // A control write keeps the old digit address when sequential data is announced.
  always_comb
  begin
    ctrl_d = ldw_ctrl_type'(data_s2_q);
    if (seq_req)
    begin
      ctrl_d.addr = ctrl_q.addr;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= ldw_ctrl_type'(CTRL_RESET);
    end
    else if (ctrl_wr)
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // Sequential fill counter; a new control write restarts or cancels it.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq_active_q <= 1'b0;
      seq_cnt_q <= 3'h0;
    end
    else if (ctrl_wr)
    begin
      seq_active_q <= seq_req;
      seq_cnt_q <= 3'h0;
    end
    else if (ram_wr && seq_active_q)
    begin
      seq_cnt_q <= seq_cnt_q + 3'h1;
      seq_active_q <= (seq_cnt_q != SEQ_LAST);
    end
  end

  // Display RAM: two banks of eight bytes, bank A in the upper half.
  genvar gi;
  generate
    for (gi = 0; gi < 2 * DIGITS; gi++)
    begin : g_ram
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          ram_q[gi] <= RAM_RESET;
        end
        else if (ram_wr && (wr_index == (ADDR_W + 1)'(gi)))
        begin
          ram_q[gi] <= data_s2_q;
        end
      end
    end
  endgenerate

  // Scan divider and digit counter; the divider clears and the counter holds while shut down.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_q <= '0;
      scan_q <= 3'h0;
    end
    else if (!ctrl_q.run)
    begin
      div_q <= '0;
    end
    else if (scan_en)
    begin
      div_q <= '0;
      scan_q <= scan_q + 3'h1;
    end
    else
    begin
      div_q <= div_q + CNT_W'(1);
    end
  end

  always_comb
  begin
    drive_d.point = rd_byte[POINT_BIT];
    if (ctrl_q.no_decode)
    begin
      drive_d.seg = rd_byte[SEG_W-1:0];
    end
    else if (ctrl_q.hex)
    begin
      drive_d.seg = ldw_hex_seg(rd_byte[3:0]);
    end
    else
    begin
      drive_d.seg = ldw_codeb_seg(rd_byte[3:0]);
    end
  end

  // One digit sinks at a time; low_power_select releases every digit and segment.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drive_q <= '0;
      digit_n_q <= '1;
    end
    else if (!ctrl_q.run)
    begin
      drive_q <= '0;
      digit_n_q <= '1;
    end
    else
    begin
      drive_q <= drive_d;
      digit_n_q <= ~(DIGITS'(1) << scan_q);
    end
  end

  assign segment_drive = drive_q;
  assign digit_sink_n = digit_n_q;

  sequence s_ctrl_wr;
    ctrl_wr;
  endsequence

  sequence s_ram_wr;
    ram_wr;
  endsequence

  sequence s_seq_start;
    ctrl_wr && seq_req;
  endsequence

  sequence s_seq_fill_wr;
    ram_wr && seq_active_q;
  endsequence

  AST_RAM_ONLY_ON_EDGE: assert property (
    @(posedge clk) disable iff (!arst_n)
    (ram_q[0] != $past(ram_q[0])) |-> $past(ram_wr) && !$past(sel_sync_q[1]))
    else $error("RAM byte changed without a write edge");

  AST_CTRL_HEX: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_ctrl_wr |=> ctrl_q.hex == $past(data_s2_q[CTRL_HEX_BIT]))
    else $error("Charset bit not taken from bit six");

  AST_CTRL_NODEC: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_ctrl_wr |=> ctrl_q.no_decode == $past(data_s2_q[CTRL_NODEC_BIT]))
    else $error("Decode bit not taken from bit five");

  AST_SEQ_START: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_seq_start |=> seq_active_q && seq_cnt_q == 3'h0)
    else $error("Sequential fill did not start at digit one");

  AST_LOW_POWER_SELECT_BLANK: assert property (
    @(posedge clk) disable iff (!arst_n)
    !ctrl_q.run ##1 !ctrl_q.run |-> digit_sink_n == 8'hFF && segment_drive == 8'h00)
    else $error("Display not blank in low_power_select");

  AST_CTRL_BANK: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_ctrl_wr |=> ctrl_q.bank_a == $past(data_s2_q[CTRL_BANK_BIT]))
    else $error("Bank bit not taken from bit three");

  AST_SINGLE_ADDR: assert property (
    @(posedge clk) disable iff (!arst_n)
    ctrl_wr && !seq_req |=> ctrl_q.addr == $past(data_s2_q[CTRL_ADDR_MSB:0]) && !seq_active_q)
    else $error("Single digit address not captured");

  AST_RAM_DATA: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_ram_wr |=> ram_q[$past(wr_index)] == $past(data_s2_q))
    else $error("RAM byte not stored at its digit");

  AST_ONE_DIGIT: assert property (
    @(posedge clk) disable iff (!arst_n)
    $onehot0(~digit_sink_n))
    else $error("More than one digit driven");

  AST_NODEC_DIRECT: assert property (
    @(posedge clk) disable iff (!arst_n)
    ctrl_q.run && ctrl_q.no_decode |=> segment_drive == {$past(rd_byte)})
    else $error("No-decode segments differ from RAM byte");

  AST_SEQ_STEP: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_seq_fill_wr |=> seq_cnt_q == $past(seq_cnt_q) + 3'h1
      && seq_active_q == ($past(seq_cnt_q) != SEQ_LAST))
    else $error("Sequential fill did not advance");

  AST_CTRL_ONLY_ON_EDGE: assert property (
    @(posedge clk) disable iff (!arst_n)
    (ctrl_q != $past(ctrl_q)) |-> $past(ctrl_wr))
    else $error("Control word changed without a control write");

  AST_CTRL_RUN: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_ctrl_wr |=> ctrl_q.run == $past(data_s2_q[CTRL_RUN_BIT]))
    else $error("Run bit not taken from bit four");

  AST_SCAN_FROZEN: assert property (
    @(posedge clk) disable iff (!arst_n)
    !ctrl_q.run |=> $stable(scan_q))
    else $error("Digit scan moved in low_power_select");

  AST_DIGIT_STEP: assert property (
    @(posedge clk) disable iff (!arst_n)
    scan_en |=> scan_q == $past(scan_q) + 3'h1)
    else $error("Digit scan did not advance");

  AST_BANK_PICK: assert property (
    @(posedge clk) disable iff (!arst_n)
    !ctrl_q.no_decode |-> rd_index[ADDR_W] == ctrl_q.bank_a)
    else $error("Decoded display reads the wrong RAM bank");

  AST_SINGLE_TARGET: assert property (
    @(posedge clk) disable iff (!arst_n)
    ram_wr && !seq_active_q |-> wr_index[ADDR_W-1:0] == ctrl_q.addr)
    else $error("Single digit write missed its address");

  AST_DECODED_POINT: assert property (
    @(posedge clk) disable iff (!arst_n)
    ctrl_q.run |=> segment_drive.point == $past(rd_byte[POINT_BIT]))
    else $error("Decimal point differs from RAM bit eight");

endmodule : ldw_write_port

// >>> ldw_host_model.sv
// Purpose: Processor model that writes bytes to the display write port.
// Assumes: The bus is changed 1 ns after a rising clock edge.
// Notes: After the hold time the bus and select show the inverse of the written values.
`timescale 1ns/1ps
module ldw_host_model
  import ldw_pkg::*;
(
  input wire logic clk,
  output logic [DATA_W-1:0] in_line,
  output logic ctrl_select,
  output logic write_strobe
);
  initial
  begin
    in_line = 8'h00;
    ctrl_select = 1'b0;
    write_strobe = 1'b0;
  end

  // The strobe stays high after the bus changes, so only its rising edge may capture.
  task automatic write_byte(input logic sel, input logic [DATA_W-1:0] data);
    @(posedge clk);
    #1;
    ctrl_select = sel;
    in_line = data;
    repeat (3) @(posedge clk);
    #1;
    write_strobe = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    in_line = ~data;
    ctrl_select = ~sel;
    repeat (3) @(posedge clk);
    #1;
    write_strobe = 1'b0;
    repeat (4) @(posedge clk);
  endtask : write_byte
endmodule : ldw_host_model

// >>> ldw_write_port_tb.sv
// Purpose: Self-checking bench for the display write port.
// Assumes: Scan step shortened to 4 clocks per digit.
// Notes: Expected drive patterns are written out by hand.
`timescale 1ns/1ps
module ldw_write_port_tb;
  import ldw_pkg::*;
  localparam int unsigned SIM_DIGIT_CYCLES = 4;
  localparam int TIMEOUT_CYCLES = 20000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [DATA_W-1:0] in_line;
  logic ctrl_select;
  logic write_strobe;
  ldw_drive_type segment_drive;
  logic [DIGITS-1:0] digit_sink_n;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  ldw_host_model host_u (
    .clk(clk),
    .in_line(in_line),
    .ctrl_select(ctrl_select),
    .write_strobe(write_strobe)
  );

  ldw_write_port #(.DIGIT_CYCLES(SIM_DIGIT_CYCLES)) dut_u (
    .clk(clk),
    .arst_n(arst_n),
    .in_line(in_line),
    .ctrl_select(ctrl_select),
    .write_strobe(write_strobe),
    .segment_drive(segment_drive),
    .digit_sink_n(digit_sink_n)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Waits a bounded time for digit k to be lit, then checks its segment drive.
  task automatic show(input int k, input logic [7:0] exp);
    logic [7:0] lit;
    int n;
    lit = ~(8'h01 << k);
    #2;
    for (n = 0; n < 100 && digit_sink_n !== lit; n++)
    begin
      @(posedge clk);
      #2;
    end
    check("digit_sink_n", digit_sink_n, lit);
    check("segment_drive", segment_drive, exp);
  endtask : show

  task automatic blank();
    repeat (3)
    begin
      repeat (10) @(posedge clk);
      #2;
      check("blank digits", digit_sink_n, 8'hFF);
      check("blank segments", segment_drive, 8'h00);
    end
  endtask : blank

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    arst_n = 1'b1;
    blank();
    host_u.write_byte(1'b1, 8'hB0);
    for (int k = 0; k < DIGITS; k++)
      host_u.write_byte(1'b0, 8'h80 ^ (8'h01 << k));
    for (int k = 0; k < DIGITS; k++)
      show(k, 8'h80 ^ (8'h01 << k));
    // Address 6 reads as 3 if the address bit order were reversed.
    host_u.write_byte(1'b1, 8'h36);
    host_u.write_byte(1'b0, 8'h5A);
    show(6, 8'h5A);
    show(3, 8'h88);
    host_u.write_byte(1'b1, 8'h50);
    host_u.write_byte(1'b0, 8'h8B);
    show(0, 8'hFC);
    host_u.write_byte(1'b1, 8'h10);
    show(0, 8'hF9);
    host_u.write_byte(1'b1, 8'h58);
    show(0, 8'h86);
    host_u.write_byte(1'b1, 8'h00);
    blank();
    end_of_test();
  end
endmodule : ldw_write_port_tb
